// File: spr_consts.svh
// Constants shared by both ends of the serial register access link.
// Function
// - Every transaction is one 40-bit datagram.
// - Device returns one bit per bit received.
// - Master holds select low whole datagram.
// - Address byte then four data bytes, 32-bit words.
// - Bit 39 high writes, low reads.
// - Master adds 0x80 to address for writes.
// - Status byte returned during bits 39..32.
// - Data word returned in every datagram.
// - After read, return that register's contents, zero for a write-only register.
// - After write, mirror the written word.
// - Read value latched right after request.
// - Read ignores data bits, register untouched.
// - Master may pipeline reads back to back.
// - Values right-aligned, two's complement or binary.
// - Read-only and write-only registers stay undisturbed.
// - Sample on rising, change after falling edge.
// - Most significant bit goes first.
// - Short datagram is invalid, no access.
// - Last 40 bits execute; extra bits delayed 40.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

`define SPR_DGRAM_BITS 6'd40
`define SPR_DGRAM_MSB 39
`define SPR_WRITE_BIT 39
`define SPR_ADDR_MSB 38
`define SPR_ADDR_LSB 32
`define SPR_DATA_MSB 31
`define SPR_WRITE_FLAG 8'h80
`define SPR_STATUS_RESET 8'h00
`define SPR_WORD_RESET 32'h00000000
`define SPR_PIN_SELECT 0
`define SPR_PIN_CLOCK 1
`define SPR_PIN_DATA 2
`define SPR_CLK_NS 4
`define SPR_HALF_BIT_NS 40
`define SPR_HALF_BIT_CYC ((`SPR_HALF_BIT_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS)

`endif

// File: spr_pkg.sv
// Types shared by both ends of the serial register access link.
package spr_pkg;
	typedef logic [39:0] spr_dgram_t;
	typedef logic [31:0] spr_word_t;
	typedef logic [7:0] spr_status_t;
	typedef logic [6:0] spr_addr_t;
	typedef enum {SPR_IDLE, SPR_LEAD, SPR_SHIFT, SPR_TAIL, SPR_GAP} spr_host_state_t;
endpackage : spr_pkg

// File: spr_link_if.sv
// Serial link between the register master and the register slave.
`timescale 1ns/10ps
interface spr_link_if;
	logic hostSelectN;
	logic hostSerialClock;
	logic hostSerialIn;
	logic hostSerialOut;
	logic hostSerialOutEn;
	logic hostSerialOutLine;

	// The released data line is pulled high.
	assign hostSerialOutLine = hostSerialOutEn ? hostSerialOut : 1'b1;

	modport device (
		input hostSelectN,
		input hostSerialClock,
		input hostSerialIn,
		output hostSerialOut,
		output hostSerialOutEn
	);

	modport host (
		output hostSelectN,
		output hostSerialClock,
		output hostSerialIn,
		input hostSerialOutLine
	);
endinterface : spr_link_if

// File: spr_sync_edge.sv
// Two-flop synchroniser with edge detection for three link pins.
`timescale 1ns/10ps
module spr_sync_edge (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] pinIn,
	output logic [2:0] level,
	output logic [2:0] rise,
	output logic [2:0] fall
);
	import spr_pkg::*;

	logic [2:0] stage1;
	logic [2:0] stage2;
	logic [2:0] stage3;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1 <= 3'h1;
			stage2 <= 3'h1;
			stage3 <= 3'h1;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign level = stage2;
	assign rise = stage2 & ~stage3;
	assign fall = ~stage2 & stage3;
endmodule : spr_sync_edge

// File: spr_device_end.sv
// Register slave end of the serial link.
`timescale 1ns/10ps
`include "spr_consts.svh"
module spr_device_end (
	input wire logic clk,
	input wire logic reset,
	spr_link_if.device link,
	input wire spr_pkg::spr_status_t eventStatus,
	input wire spr_pkg::spr_word_t regReadData,
	input wire logic regReadOnly,
	input wire logic regWriteOnly,
	output spr_pkg::spr_addr_t regAddr,
	output spr_pkg::spr_word_t regWriteData,
	output logic regWrite,
	output logic regRead,
	output logic cmdInvalid
);
	import spr_pkg::*;

	logic [2:0] pinLevel;
	logic [2:0] pinRise;
	logic [2:0] pinFall;
	logic inFrame;
	logic frameStart;
	logic frameEnd;
	logic clockRise;
	logic clockFall;
	logic dataIn;
	logic [5:0] bitCount;
	logic frameComplete;
	spr_dgram_t shiftReg;
	logic outBit;
	spr_word_t returnWord;
	logic writePend;
	logic readPend;

	// Every pin from the master passes two flops before use.
	spr_sync_edge pinSync (
		.clk(clk),
		.reset(reset),
		.pinIn({link.hostSerialIn, link.hostSerialClock, link.hostSelectN}),
		.level(pinLevel),
		.rise(pinRise),
		.fall(pinFall)
	);

	assign frameStart = pinFall[`SPR_PIN_SELECT];
	assign frameEnd = pinRise[`SPR_PIN_SELECT] & inFrame;
	assign clockRise = pinRise[`SPR_PIN_CLOCK] & inFrame;
	assign clockFall = pinFall[`SPR_PIN_CLOCK] & inFrame;
	assign dataIn = pinLevel[`SPR_PIN_DATA];
	assign frameComplete = (bitCount == `SPR_DGRAM_BITS);

	// The frame is open from the select falling to it rising again.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			inFrame <= 1'b0;
		end else if (frameStart) begin
			inFrame <= 1'b1;
		end else if (pinRise[`SPR_PIN_SELECT]) begin
			inFrame <= 1'b0;
		end
	end

	// The count saturates at a full datagram so longer frames still execute.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bitCount <= 6'h00;
		end else if (frameStart) begin
			bitCount <= 6'h00;
		end else if (clockRise && !frameComplete) begin
			bitCount <= bitCount + 6'h01;
		end
	end

	// One register serves as reply source and command collector.
	// Bits past 40 fall out of the top forty clocks after entering.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shiftReg <= {`SPR_STATUS_RESET, `SPR_WORD_RESET};
		end else if (frameStart) begin
			shiftReg <= {eventStatus, returnWord};
		end else if (clockRise) begin
			shiftReg <= {shiftReg[`SPR_DGRAM_MSB - 1:0], dataIn};
		end
	end

	// The reply bit changes only when select falls and after a falling serial clock edge.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			outBit <= 1'b0;
		end else if (frameStart) begin
			outBit <= eventStatus[7];
		end else if (clockFall) begin
			outBit <= shiftReg[`SPR_DGRAM_MSB];
		end
	end

	assign link.hostSerialOut = outBit;
	assign link.hostSerialOutEn = inFrame;

	// Only the last forty bits before select rises form the command.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			writePend <= 1'b0;
			readPend <= 1'b0;
			cmdInvalid <= 1'b0;
		end else begin
			writePend <= frameEnd && frameComplete && shiftReg[`SPR_WRITE_BIT];
			readPend <= frameEnd && frameComplete && !shiftReg[`SPR_WRITE_BIT];
			cmdInvalid <= frameEnd && !frameComplete;
		end
	end

	// Address and data are held until the next command replaces them.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regAddr <= 7'h00;
			regWriteData <= `SPR_WORD_RESET;
		end else if (frameEnd && frameComplete) begin
			regAddr <= shiftReg[`SPR_ADDR_MSB:`SPR_ADDR_LSB];
			regWriteData <= shiftReg[`SPR_DATA_MSB:0];
		end
	end

	// Access qualifiers come from the register file for the held address.
	assign regWrite = writePend & ~regReadOnly;
	assign regRead = readPend & ~regWriteOnly;

	// The word for the next frame is latched the cycle after the request.
	// Register values arrive right-aligned and zero or sign extended.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			returnWord <= `SPR_WORD_RESET;
		end else if (writePend) begin
			returnWord <= regWriteData;
		end else if (readPend) begin
			returnWord <= regWriteOnly ? `SPR_WORD_RESET : regReadData;
		end
	end

endmodule : spr_device_end

// File: spr_host_end.sv
// Register master end of the serial link.
`timescale 1ns/10ps
`include "spr_consts.svh"
module spr_host_end (
	input wire logic clk,
	input wire logic reset,
	spr_link_if.host link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdWrite,
	input wire spr_pkg::spr_addr_t cmdAddr,
	input wire spr_pkg::spr_word_t cmdData,
	output logic rspValid,
	output spr_pkg::spr_status_t rspStatus,
	output spr_pkg::spr_word_t rspData
);
	import spr_pkg::*;

	localparam logic [7:0] HALF_CYC = 8'(`SPR_HALF_BIT_CYC);

	spr_host_state_t state;
	logic [7:0] divCount;
	logic halfTick;
	logic [5:0] bitCount;
	spr_dgram_t txReg;
	spr_dgram_t rxReg;
	logic replyMeta;
	logic replySync;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			replyMeta <= 1'b1;
			replySync <= 1'b1;
		end else begin
			replyMeta <= link.hostSerialOutLine;
			replySync <= replyMeta;
		end
	end

	// Divider producing one enable pulse per half bit period.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			divCount <= 8'h00;
		end else if (state == SPR_IDLE || halfTick) begin
			divCount <= 8'h00;
		end else begin
			divCount <= divCount + 8'h01;
		end
	end

	assign halfTick = (divCount == HALF_CYC - 8'h01);
	assign cmdReady = (state == SPR_IDLE);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= SPR_IDLE;
			bitCount <= 6'h00;
			txReg <= {`SPR_STATUS_RESET, `SPR_WORD_RESET};
			rxReg <= {`SPR_STATUS_RESET, `SPR_WORD_RESET};
			link.hostSelectN <= 1'b1;
			link.hostSerialClock <= 1'b0;
			link.hostSerialIn <= 1'b0;
			rspValid <= 1'b0;
			rspStatus <= `SPR_STATUS_RESET;
			rspData <= `SPR_WORD_RESET;
		end else begin
			rspValid <= 1'b0;
			unique case (state)
				SPR_IDLE: begin
					if (cmdValid) begin
						// Writes carry the address plus 0x80.
						txReg <= {({1'b0, cmdAddr} | (cmdWrite ? `SPR_WRITE_FLAG : 8'h00)),
							cmdData};
						link.hostSerialIn <= cmdWrite;
						link.hostSelectN <= 1'b0;
						bitCount <= 6'h00;
						state <= SPR_LEAD;
					end
				end
				SPR_LEAD: begin
					if (halfTick) begin
						state <= SPR_SHIFT;
					end
				end
				SPR_SHIFT: begin
					if (halfTick && !link.hostSerialClock) begin
						link.hostSerialClock <= 1'b1;
						rxReg <= {rxReg[`SPR_DGRAM_MSB - 1:0], replySync};
					end else if (halfTick) begin
						link.hostSerialClock <= 1'b0;
						txReg <= {txReg[`SPR_DGRAM_MSB - 1:0], 1'b0};
						link.hostSerialIn <= txReg[`SPR_DGRAM_MSB - 1];
						bitCount <= bitCount + 6'h01;
						if (bitCount == `SPR_DGRAM_BITS - 6'h01) begin
							state <= SPR_TAIL;
						end
					end
				end
				SPR_TAIL: begin
					if (halfTick) begin
						link.hostSelectN <= 1'b1;
						rspValid <= 1'b1;
						rspStatus <= rxReg[`SPR_DGRAM_MSB:`SPR_ADDR_LSB];
						rspData <= rxReg[`SPR_DATA_MSB:0];
						state <= SPR_GAP;
					end
				end
				SPR_GAP: begin
					if (halfTick) begin
						state <= SPR_IDLE;
					end
				end
			endcase
		end
	end

endmodule : spr_host_end

// File: spr_link_sva.sv
// Concurrent checks on the serial link between the two ends.
`timescale 1ns/10ps
module spr_link_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic hostSelectN,
	input wire logic hostSerialClock,
	input wire logic hostSerialIn,
	input wire logic hostSerialOut,
	input wire logic hostSerialOutEn
);
	logic [5:0] nClk;
	logic prevClk;
	logic prevSel;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Counts serial clock rises within one frame.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			nClk <= 6'h00;
			prevClk <= 1'b0;
			prevSel <= 1'b1;
		end else begin
			prevClk <= hostSerialClock;
			prevSel <= hostSelectN;
			if (hostSelectN && prevSel) begin
				nClk <= 6'h00;
			end else if (hostSerialClock && !prevClk) begin
				nClk <= nClk + 6'h01;
			end
		end
	end
	sequence s_start; $fell(hostSelectN); endsequence
	sequence s_drive; ##[1:5] hostSerialOutEn; endsequence
	property p_oeOn; s_start |-> s_drive; endproperty
	property p_oeOff; $rose(hostSelectN) |-> ##[1:5] !hostSerialOutEn; endproperty
	property p_idle; hostSelectN [*6] |-> !hostSerialOutEn; endproperty
	property p_selLow; $rose(hostSerialClock) |-> !hostSelectN; endproperty
	property p_clkIdle; hostSelectN |-> !hostSerialClock; endproperty
	property p_hold; $rose(hostSerialClock) |=> $stable(hostSerialIn) [*3]; endproperty
	property p_outFall;
		hostSerialOutEn && $past(hostSerialOutEn) && $changed(hostSerialOut) |-> !hostSerialClock;
	endproperty
	property p_count; $rose(hostSelectN) |-> nClk == 6'h28; endproperty
	a_oeOn: assert property (p_oeOn)
		else $error("Output not driven at frame start");
	a_oeOff: assert property (p_oeOff)
		else $error("Output not released after frame");
	a_idle: assert property (p_idle)
		else $error("Output driven while deselected");
	a_selLow: assert property (p_selLow)
		else $error("Clock rise while deselected");
	a_clkIdle: assert property (p_clkIdle)
		else $error("Clock high while deselected");
	a_hold: assert property (p_hold)
		else $error("Input data moved after rising edge");
	a_outFall: assert property (p_outFall)
		else $error("Output changed while clock high");
	a_count: assert property (p_count)
		else $error("Frame length not 40 clocks");
endmodule : spr_link_sva

// File: test_spi_register_access_slave.sv
// Testbench sending register datagrams across both link ends.
`timescale 1ns/10ps
module test_spi_register_access_slave;
	import spr_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cmdValid = 1'b0;
	logic cmdWrite = 1'b0;
	logic cmdReady, rspValid, regWrite, regRead, cmdInvalid;
	int numReads = 0;
	int expReads = 0;
	int numInvalid = 0;
	spr_addr_t cmdAddr = 7'h00;
	spr_addr_t regAddr;
	spr_word_t cmdData = 32'h00000000;
	spr_word_t expData = 32'h00000000;
	spr_word_t rspData, regWriteData;
	spr_word_t mem[128];
	spr_word_t model[128];
	spr_status_t eventStatus = 8'h00;
	spr_status_t rspStatus;
	spr_dgram_t mosi, miso;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	spr_link_if i_spr_link_if();
	spr_device_end i_spr_device_end(.clk(clk), .reset(reset), .link(i_spr_link_if),
		.eventStatus(eventStatus), .regReadData(mem[regAddr]),
		.regReadOnly(regAddr == 7'h01), .regWriteOnly(regAddr == 7'h02), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
		.cmdInvalid(cmdInvalid));
	spr_host_end i_spr_host_end(.clk(clk), .reset(reset), .link(i_spr_link_if),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
		.cmdData(cmdData), .rspValid(rspValid), .rspStatus(rspStatus), .rspData(rspData));
	spr_link_sva i_spr_link_sva(.clk(clk), .reset(reset),
		.hostSelectN(i_spr_link_if.hostSelectN), .hostSerialIn(i_spr_link_if.hostSerialIn),
		.hostSerialClock(i_spr_link_if.hostSerialClock),
		.hostSerialOut(i_spr_link_if.hostSerialOut),
		.hostSerialOutEn(i_spr_link_if.hostSerialOutEn));
	initial begin
		forever #2 clk = ~clk;
	end
	always @(negedge clk) begin
		if (regWrite === 1'b1) begin
			mem[regAddr] = regWriteData;
		end
		if (regRead === 1'b1) begin
			numReads++;
		end
		if (cmdInvalid === 1'b1) begin
			numInvalid++;
		end
	end
	always @(posedge i_spr_link_if.hostSerialClock) begin
		mosi = {mosi[38:0], i_spr_link_if.hostSerialIn};
		miso = {miso[38:0], i_spr_link_if.hostSerialOutLine};
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 12000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (!ok) begin
			num_errors++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : check
	task automatic xfer(input logic w, input spr_addr_t a, input spr_word_t d,
		input spr_status_t s);
		int n;
		@(negedge clk);
		eventStatus = s;
		cmdWrite = w;
		cmdAddr = a;
		cmdData = d;
		n = 0;
		while (cmdReady !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check(n < 2000, "host never ready");
		cmdValid = 1'b1;
		@(negedge clk);
		cmdValid = 1'b0;
		n = 0;
		while (rspValid !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check(n < 2000, "no response");
		check(rspStatus === s, "status byte");
		check(rspData === expData, "reply word");
		check(mosi === {w, a, d}, "request bit order");
		check(miso === {s, expData}, "reply bits");
		expData = w ? d : ((a == 7'h02) ? 32'h00000000 : model[a]);
		if (!w && a != 7'h02) begin
			expReads++;
		end
		if (w && a != 7'h01) begin
			model[a] = d;
		end
		repeat (8) @(negedge clk);
		check(mem[a] === model[a], "register state");
		check(numReads == expReads, "read strobe count");
		check(numInvalid == 0, "full frame flagged short");
	endtask : xfer
	task automatic tally_and_finish();
		$display("Errors: %0d, checks: %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		for (int k = 0; k < 128; k++) begin
			mem[k] = {25'h0B40000, k[6:0]};
			model[k] = mem[k];
		end
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		xfer(1'b1, 7'h05, 32'h00ABCDEF, 8'hA5);
		xfer(1'b1, 7'h05, 32'h00123456, 8'h5A);
		xfer(1'b0, 7'h05, 32'hFFFFFFFF, 8'h01);
		xfer(1'b0, 7'h06, 32'h00000000, 8'h80);
		xfer(1'b1, 7'h01, 32'hDEADBEEF, 8'hFF);
		xfer(1'b0, 7'h02, 32'h00000000, 8'h00);
		xfer(1'b1, 7'h7F, 32'h80000001, 8'h3C);
		xfer(1'b0, 7'h7F, 32'h00000000, 8'hC3);
		xfer(1'b0, 7'h00, 32'h00000000, 8'h7E);
		tally_and_finish();
	end
endmodule : test_spi_register_access_slave
